// ===== dv/tb_tqf_fifo.sv
// Self-checking bench for the three-queue cell FIFO.
`timescale 1ns/1ps
module tb_tqf_fifo;
  logic        clk = 1'b0, rclk = 1'b0, rst = 1'b1, cstart = 1'b0, aclr = 1'b0, req_n = 1'b1, ds_n = 1'b1;
  logic [17:0] wdata = 18'h00000;
  logic [2:0]  wen = 3'h0;
  logic [7:0]  pdata = 8'h00;
  logic [3:0]  paddr = 4'h0;
  logic        m_go = 1'b0, m_slow = 1'b0, ren, wrdy, alarm_n, rvalid, rsoc;
  logic [1:0]  m_sel = 2'h0, qsel;
  logic [6:0]  m_want = 7'h00, got;
  logic [2:0]  flags, cready;
  logic [8:0]  prdata;
  logic [17:0] rdata;
  logic [7:0]  cfgv [0:10];
  logic [8:0]  dflt [0:10] = '{9'h000, 9'h008, 9'h006, 9'h01B, 9'h047, 9'h046, 9'h033, 9'h032, 9'h00D, 9'h00C,
                               9'h002};
  int          n_errors = 0, checked = 0, cyc = 0, n_soc = 0;

  always #25 clk = ~clk;
  always #7.5 rclk = ~rclk;

  // Cell starts are counted as they come, since the pulse lasts one read clock only.
  always @(posedge rclk)
    if (rvalid === 1'b1 && rsoc === 1'b1)
      n_soc++;

  tqf_fifo DUT (.I_CORE_CLK(clk), .I_READ_CLK(rclk), .I_RST(rst), .I_WRITE_DATA(wdata), .I_QUEUE_WRITE_ENABLE(wen),
    .I_INPUT_CELL_START(cstart), .I_ALARM_CLEAR(aclr), .O_WRITE_READY(wrdy), .O_THRESHOLD_FLAG(flags),
    .O_CELL_BOUNDARY_ALARM_N(alarm_n), .I_CONFIG_BUS_REQUEST_N(req_n), .I_CONFIG_DATA_STROBE_N(ds_n),
    .I_PROG_DATA(pdata), .I_PROG_ADDR(paddr), .O_PROG_RDATA(prdata), .I_READ_ENABLE(ren), .I_QUEUE_SELECT(qsel),
    .O_READ_DATA(rdata), .O_READ_VALID(rvalid), .O_CELL_START(rsoc), .O_CELL_READY(cready));

  tqf_sink_model SINK (.i_clk(rclk), .i_rst(rst), .i_go(m_go), .i_sel(m_sel), .i_want(m_want), .i_slow(m_slow),
    .i_valid(rvalid), .i_data(rdata), .o_read_enable(ren), .o_queue_select(qsel), .o_got(got));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [17:0] g, input logic [17:0] e, input string what);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask

  task automatic wrap_up;
    $display("Counts: %0d checks, %0d mismatches", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // The ceiling sits well above the several hundred cycles the tests need.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic do_reset;
    rst = 1'b1;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task automatic load(input int n);
    @(negedge clk);
    req_n = 1'b0;
    repeat (3) @(negedge clk);
    chk({17'h0, wrdy}, 18'h0, "write ready low");
    for (int i = 0; i < n; i++)
    begin
      pdata = cfgv[i];
      repeat (4) @(negedge clk);
      ds_n = 1'b0;
      repeat (4) @(negedge clk);
      ds_n = 1'b1;
    end
    repeat (4) @(negedge clk);
    req_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask

  task automatic rb(input logic [3:0] a, input logic [8:0] e);
    @(negedge clk);
    paddr = a;
    repeat (5) @(negedge clk);
    chk({9'h0, prdata}, {9'h0, e}, "register readback");
  endtask

  task automatic wcell(input int q, input logic [17:0] base, input int n, input int bad);
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk);
      wen = 3'(1 << q);
      cstart = (i == 0 || i == bad);
      wdata = base + 18'(i);
    end
    @(negedge clk);
    wen = 3'h0;
    cstart = 1'b0;
    repeat (6) @(negedge clk);
  endtask

  task automatic rd(input logic [1:0] s, input int n, input logic slow);
    @(negedge clk);
    m_sel = s;
    m_want = 7'(n);
    m_slow = slow;
    m_go = 1'b1;
    @(negedge clk);
    for (int i = 0; i < 60 && got !== 7'(n); i++)
      @(negedge clk);
    m_go = 1'b0;
    repeat (8) @(negedge clk);
  endtask

  task automatic cmpw(input int n, input logic [17:0] base);
    for (int i = 0; i < n; i++)
      chk(SINK.words[i], base + 18'(i), "read data");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults;
    for (int i = 0; i < 11; i++)
      rb(4'(i), dflt[i]);
    chk({15'h0, flags}, 18'h7, "flags high");
    chk({15'h0, cready}, 18'h0, "no cells");
    $display("test defaults done");
  endtask

  task automatic t_config;
    cfgv = '{8'h00, 8'h01, 8'h00, 8'h0A, 8'h02, 8'h01, 8'h01, 8'h00, 8'h01, 8'h00, 8'h1F};
    load(11);
    for (int i = 0; i < 10; i++)
      rb(4'(i), {1'b0, cfgv[i]});
    rb(4'hA, 9'h00F);
    rb(4'hB, 9'h000);
    $display("test config done");
  endtask

  task automatic t_queues;
    wcell(0, 18'h01000, 10, 99);
    wcell(0, 18'h02000, 10, 99);
    chk({17'h0, flags[0]}, 18'h0, "q1 flag low");
    wcell(1, 18'h03000, 10, 99);
    chk({17'h0, cready[1]}, 18'h0, "zero queue");
    rd(2'h2, 1, 1'b0);
    chk({11'h0, got}, 18'h0, "refused read");
    rd(2'h1, 10, 1'b0);
    cmpw(10, 18'h01000);
    chk({17'h0, flags[0]}, 18'h1, "q1 flag high");
    rd(2'h0, 10, 1'b1);
    cmpw(10, 18'h02000);
    wcell(2, 18'h04000, 10, 99);
    chk({17'h0, flags[2]}, 18'h0, "q3 flag low");
    rd(2'h3, 10, 1'b0);
    cmpw(10, 18'h04000);
    chk({17'h0, flags[2]}, 18'h1, "q3 flag high");
    chk(18'(n_soc), 18'h3, "cell starts");
    $display("test queues done");
  endtask

  task automatic t_alarm;
    wcell(0, 18'h05000, 10, 4);
    chk({17'h0, alarm_n}, 18'h0, "alarm low");
    @(negedge clk);
    aclr = 1'b1;
    @(negedge clk);
    aclr = 1'b0;
    @(negedge clk);
    chk({17'h0, alarm_n}, 18'h1, "alarm cleared");
    wcell(0, 18'h06000, 10, 99);
    rd(2'h0, 10, 1'b0);
    cmpw(10, 18'h06000);
    $display("test alarm done");
  endtask

  task automatic t_nine;
    logic [8:0] b;
    do_reset();
    cfgv = '{8'h0B, 8'h08, 8'h06, 8'h0A, 8'h47, 8'h46, 8'h33, 8'h32, 8'h0D, 8'h0C, 8'h00};
    load(10);
    wcell(0, 18'h00100, 20, 99);
    rd(2'h0, 20, 1'b1);
    for (int k = 0; k < 20; k++)
    begin
      b = 9'h100 + 9'(k ^ 1);
      chk(SINK.words[k], {b, b}, "byte lanes");
    end
    chk(18'(n_soc), 18'h5, "one start per byte cell");
    $display("test nine-bit done");
  endtask

  // Odd byte count: the stuffed half is written as zero and skipped on read.
  task automatic t_stuff;
    logic [8:0] b;
    do_reset();
    cfgv = '{8'h1D, 8'h08, 8'h06, 8'h0A, 8'h47, 8'h46, 8'h33, 8'h32, 8'h0D, 8'h0C, 8'h00};
    load(10);
    wcell(0, 18'h00080, 19, 99);
    rd(2'h1, 19, 1'b0);
    for (int k = 0; k < 19; k++)
    begin
      b = 9'h080 + 9'(k);
      chk(SINK.words[k], {b, b}, "destuffed bytes");
    end
    chk({17'h0, cready[0]}, 18'h0, "stuffed cell drained");
    chk(18'(n_soc), 18'h6, "stuffed cell start");
    $display("test stuffing done");
  endtask

  initial
  begin
    do_reset();
    t_defaults();
    t_config();
    t_queues();
    t_alarm();
    t_nine();
    t_stuff();
    wrap_up();
  end
endmodule

bind tqf_fifo tqf_fifo_asserts u_chk (.I_CORE_CLK(I_CORE_CLK), .I_READ_CLK(I_READ_CLK), .I_RST(I_RST),
  .I_QUEUE_WRITE_ENABLE(I_QUEUE_WRITE_ENABLE), .I_ALARM_CLEAR(I_ALARM_CLEAR),
  .I_CONFIG_BUS_REQUEST_N(I_CONFIG_BUS_REQUEST_N), .I_READ_ENABLE(I_READ_ENABLE), .I_QUEUE_SELECT(I_QUEUE_SELECT),
  .O_WRITE_READY(O_WRITE_READY), .O_THRESHOLD_FLAG(O_THRESHOLD_FLAG), .O_CELL_BOUNDARY_ALARM_N(O_CELL_BOUNDARY_ALARM_N),
  .O_READ_VALID(O_READ_VALID), .O_CELL_START(O_CELL_START), .O_CELL_READY(O_CELL_READY));

// ===== dv/tqf_fifo_asserts.sv
// Port-level assertions for the three-queue cell FIFO.
`timescale 1ns/1ps
module tqf_fifo_asserts
  import tqf_pkg::*;
(
  input wire logic       I_CORE_CLK,
  input wire logic       I_READ_CLK,
  input wire logic       I_RST,
  input wire logic [2:0] I_QUEUE_WRITE_ENABLE,
  input wire logic       I_ALARM_CLEAR,
  input wire logic       I_CONFIG_BUS_REQUEST_N,
  input wire logic       I_READ_ENABLE,
  input wire logic [1:0] I_QUEUE_SELECT,
  input wire logic       O_WRITE_READY,
  input wire logic [2:0] O_THRESHOLD_FLAG,
  input wire logic       O_CELL_BOUNDARY_ALARM_N,
  input wire logic       O_READ_VALID,
  input wire logic       O_CELL_START,
  input wire logic [2:0] O_CELL_READY
);
  logic [1:0] sel_idx;

  // Select codes 00 and 01 both land on queue one.
  assign sel_idx = (I_QUEUE_SELECT == 2'h3) ? 2'h2 : ((I_QUEUE_SELECT == 2'h2) ? 2'h1 : 2'h0);

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_req_fall;
    $fell(I_CONFIG_BUS_REQUEST_N);
  endsequence

  sequence s_req_low;
    !I_CONFIG_BUS_REQUEST_N [*3];
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  chk_ready_drop: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    s_req_fall |-> ##[0:2] !O_WRITE_READY) else $error("write ready late to drop");
  chk_ready_hold: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    s_req_low |-> !O_WRITE_READY) else $error("write ready high during config");
  chk_ready_back: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    $rose(I_CONFIG_BUS_REQUEST_N) |-> ##[0:2] O_WRITE_READY) else $error("write ready did not return");
  chk_alarm_hold: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    !O_CELL_BOUNDARY_ALARM_N && !I_ALARM_CLEAR |=> !O_CELL_BOUNDARY_ALARM_N) else $error("alarm left early");
  chk_alarm_clear: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    $rose(O_CELL_BOUNDARY_ALARM_N) |-> $past(I_ALARM_CLEAR)) else $error("alarm cleared without clear");
  chk_alarm_cause: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    $fell(O_CELL_BOUNDARY_ALARM_N) |-> $past(|I_QUEUE_WRITE_ENABLE)) else $error("alarm without a write");
  chk_flag_cause: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    $fell(O_THRESHOLD_FLAG[0]) |-> $past(I_QUEUE_WRITE_ENABLE[0], 2) || $past(I_QUEUE_WRITE_ENABLE[0], 3))
    else $error("queue one flag fell without writes");
  chk_valid_cause: assert property (@(posedge I_READ_CLK) disable iff (I_RST)
    O_READ_VALID |-> $past(I_READ_ENABLE)) else $error("read valid without read enable");
  chk_start_valid: assert property (@(posedge I_READ_CLK) disable iff (I_RST)
    O_CELL_START |-> O_READ_VALID) else $error("cell start without valid");
  chk_empty_read: assert property (@(posedge I_READ_CLK) disable iff (I_RST)
    I_READ_ENABLE && !O_CELL_READY[sel_idx] |=> !O_READ_VALID) else $error("read from queue with no cell");
endmodule

// ===== dv/tqf_sink_model.sv
// Cell sink on the read clock: issues a given number of reads and keeps the returned words.
`timescale 1ns/1ps
module tqf_sink_model
  import tqf_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_go,
  input  wire logic [1:0]  i_sel,
  input  wire logic [6:0]  i_want,
  input  wire logic        i_slow,
  input  wire logic        i_valid,
  input  wire logic [17:0] i_data,
  output logic             o_read_enable,
  output logic [1:0]       o_queue_select,
  output logic [6:0]       o_got
);
  logic [17:0] words [0:63];
  logic [6:0]  issued;
  logic        stall;
  logic        go_q;

  // Select holds for a whole burst so a 9-bit word is never split; between bursts it wanders.
  always @(negedge i_clk or posedge i_rst)
    if (i_rst)
    begin
      o_read_enable  <= 1'b0;
      o_queue_select <= 2'h0;
      issued         <= 7'h00;
      stall          <= 1'b0;
    end
    else if (!i_go)
    begin
      o_read_enable  <= 1'b0;
      o_queue_select <= ~o_queue_select;
      issued         <= 7'h00;
    end
    else
    begin
      stall          <= i_slow && !stall;
      o_queue_select <= i_sel;
      o_read_enable  <= (issued < i_want) && !(i_slow && stall);
      if ((issued < i_want) && !(i_slow && stall))
        issued <= issued + 7'h01;
    end

  // Either lane may be wired to the board, so the whole word is kept.
  // The count outlives the burst so the bench can still judge it; only a new burst restarts it.
  always @(posedge i_clk or posedge i_rst)
    if (i_rst)
    begin
      o_got <= 7'h00;
      go_q  <= 1'b0;
    end
    else
    begin
      go_q <= i_go;
      if (i_go && !go_q)
        o_got <= 7'h00;
      else if (i_valid)
      begin
        words[o_got[5:0]] <= i_data;
        o_got             <= o_got + 7'h01;
      end
    end
endmodule

// ===== logic/tqf_fifo.sv
// Three-queue cell FIFO: 4096 x 18 store, write side on the core clock, read side on its own clock.
`timescale 1ns/1ps

module tqf_fifo
  import tqf_pkg::*;
(
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_READ_CLK,
  input  wire logic        I_RST,
  input  wire logic [17:0] I_WRITE_DATA,
  input  wire logic [2:0]  I_QUEUE_WRITE_ENABLE,
  input  wire logic        I_INPUT_CELL_START,
  input  wire logic        I_ALARM_CLEAR,
  output logic             O_WRITE_READY,
  output logic [2:0]       O_THRESHOLD_FLAG,
  output logic             O_CELL_BOUNDARY_ALARM_N,
  input  wire logic        I_CONFIG_BUS_REQUEST_N,
  input  wire logic        I_CONFIG_DATA_STROBE_N,
  input  wire logic [7:0]  I_PROG_DATA,
  input  wire logic [3:0]  I_PROG_ADDR,
  output logic [8:0]       O_PROG_RDATA,
  input  wire logic        I_READ_ENABLE,
  input  wire logic [1:0]  I_QUEUE_SELECT,
  output logic [17:0]      O_READ_DATA,
  output logic             O_READ_VALID,
  output logic             O_CELL_START,
  output logic [2:0]       O_CELL_READY
);

`include "tqf_regs.svh"

  ////////////////////////////////////////////////////////////////////////////
  // Decoding shared by both domains.

  localparam tqf_cfg_t CFG_RST = {`TQF_RST_Q3_LOWER, `TQF_RST_Q3_UPPER, `TQF_RST_Q2_LOWER, `TQF_RST_Q2_UPPER,
                                  `TQF_RST_Q1_LOWER, `TQF_RST_Q1_UPPER, `TQF_RST_CELL_LEN, `TQF_RST_Q2_LEN,
                                  `TQF_RST_Q1_LEN, `TQF_RST_FORMAT};

  // Block counts per queue; an oversized pair is clipped so queue three never goes negative.
  function automatic logic [4:0] q_blocks(input logic [4:0] l1, input logic [3:0] l2, input logic [1:0] q);
    logic [4:0] b1;
    logic [4:0] b2;
    b1 = (l1 > `TQF_TOTAL_BLOCKS) ? `TQF_TOTAL_BLOCKS : l1;
    b2 = ({1'b0, l2} > `TQF_TOTAL_BLOCKS - b1) ? `TQF_TOTAL_BLOCKS - b1 : {1'b0, l2};
    case (q)
      2'h0:    q_blocks = b1;
      2'h1:    q_blocks = b2;
      default: q_blocks = `TQF_TOTAL_BLOCKS - b1 - b2;
    endcase
  endfunction

  function automatic logic [12:0] q_cap(input logic [4:0] l1, input logic [3:0] l2, input logic [1:0] q);
    q_cap = {8'h00, q_blocks(l1, l2, q)} << `TQF_BLOCK_SHIFT;
  endfunction

  function automatic logic [11:0] q_base(input logic [4:0] l1, input logic [3:0] l2, input logic [1:0] q);
    logic [12:0] s;
    s = 13'h0000;
    if (q != 2'h0)
      s = q_cap(l1, l2, 2'h0);
    if (q == 2'h2)
      s = s + q_cap(l1, l2, 2'h1);
    q_base = s[11:0];
  endfunction

  function automatic logic [11:0] q_next(input logic [11:0] p, input logic [12:0] cap);
    q_next = ({1'b0, p} + 13'h0001 >= cap) ? 12'h000 : p + 12'h001;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Storage.

  logic [17:0] mem [0:`TQF_MEM_WORDS-1];
  logic        mem_we;
  logic [11:0] mem_waddr;
  logic [17:0] mem_wdata;
  tqf_wr_t     w_q;
  tqf_wr_t     w_d;
  tqf_rd_t     r_q;
  tqf_rd_t     r_d;

  always_ff @(posedge I_CORE_CLK)
  begin
    if (mem_we)
      mem[mem_waddr] <= mem_wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write domain: data input, configuration port, fill counts and flags.

  always_comb
  begin
    logic [1:0]  sel;
    logic [12:0] cap;
    logic [15:0] used;
    logic [5:0]  last;
    logic        in9;
    logic        big;
    logic        stuff;
    logic        at_start;
    logic        commit;
    logic [2:0]  inc;
    logic [3:0]  ci;
    logic [8:0]  msk;
    logic [8:0]  up;
    logic [8:0]  lo;
    sel      = 2'h0;
    cap      = 13'h0000;
    used     = 16'h0000;
    last     = 6'h00;
    in9      = 1'b0;
    big      = 1'b0;
    stuff    = 1'b0;
    at_start = 1'b0;
    commit   = 1'b0;
    inc      = 3'h0;
    ci       = 4'h0;
    msk      = 9'h000;
    up       = 9'h000;
    lo       = 9'h000;
    w_d       = w_q;
    mem_we    = 1'b0;
    mem_waddr = 12'h000;
    mem_wdata = 18'h00000;

    // Pins from the microcontroller are asynchronous and pass two flip-flops first.
    w_d.config_bus_request_s  = {w_q.config_bus_request_s[0], I_CONFIG_BUS_REQUEST_N};
    w_d.ds_s    = {w_q.ds_s[1:0], I_CONFIG_DATA_STROBE_N};
    w_d.p_s1    = I_PROG_DATA;
    w_d.p_s2    = w_q.p_s1;
    w_d.a_s1    = I_PROG_ADDR;
    w_d.a_s2    = w_q.a_s1;
    w_d.rtog_s1 = r_q.tog;
    w_d.rtog_s2 = w_q.rtog_s1;
    w_d.rtog_s3 = w_q.rtog_s2;

    // The strobe is sampled, so it must stay high and low for a few core clocks each.
    ci = w_q.cfg_cnt;
    if (!w_q.config_bus_request_s[1] && w_q.ds_s[2] && !w_q.ds_s[1] && ci < `TQF_NUM_WRITABLE)
    begin
      unique case (ci)
        `TQF_IDX_FORMAT:   msk = `TQF_MSK_FORMAT;
        `TQF_IDX_Q1_LEN:   msk = `TQF_MSK_Q1_LEN;
        `TQF_IDX_Q2_LEN:   msk = `TQF_MSK_Q2_LEN;
        `TQF_IDX_CELL_LEN: msk = `TQF_MSK_CELL_LEN;
        `TQF_IDX_Q3_UPPER,
        `TQF_IDX_Q3_LOWER: msk = `TQF_MSK_THR8;
        default:           msk = `TQF_MSK_THR9;
      endcase
      w_d.cfg[ci]  = {1'b0, w_q.p_s2} & msk;
      w_d.cfg_cnt  = ci + 4'h1;
    end

    if (w_q.a_s2 < `TQF_NUM_WRITABLE)
      w_d.rdata = w_q.cfg[w_q.a_s2];
    else if (w_q.a_s2 == `TQF_IDX_Q3_LEN)
      w_d.rdata = {4'h0, (q_blocks(w_q.cfg[`TQF_IDX_Q1_LEN][4:0], w_q.cfg[`TQF_IDX_Q2_LEN][3:0], 2'h2) >
                   5'h0F) ? 5'h0F : q_blocks(w_q.cfg[`TQF_IDX_Q1_LEN][4:0], w_q.cfg[`TQF_IDX_Q2_LEN][3:0], 2'h2)};
    else
      w_d.rdata = 9'h000;

    in9   = w_q.cfg[`TQF_IDX_FORMAT][`TQF_FMT_IN_WIDTH];
    big   = w_q.cfg[`TQF_IDX_FORMAT][`TQF_FMT_IN_ORDER];
    stuff = w_q.cfg[`TQF_IDX_FORMAT][`TQF_FMT_IN_STUFF];
    last  = w_q.cfg[`TQF_IDX_CELL_LEN][5:0] - 6'h01;
    sel   = I_QUEUE_WRITE_ENABLE[2] ? 2'h2 : (I_QUEUE_WRITE_ENABLE[1] ? 2'h1 : 2'h0);
    cap   = q_cap(w_q.cfg[`TQF_IDX_Q1_LEN][4:0], w_q.cfg[`TQF_IDX_Q2_LEN][3:0], sel);
    used  = 16'(w_q.q[sel].cells * w_q.cfg[`TQF_IDX_CELL_LEN][5:0]) + {10'h000, w_q.q[sel].widx};

    if (I_ALARM_CLEAR)
    begin
      w_d.alarm_n = 1'b1;
      w_d.half    = 1'b0;
      for (int i = 0; i < 3; i++)
      begin
        w_d.q[i].wptr = w_q.q[i].cstart;
        w_d.q[i].widx = 6'h00;
      end
    end
    else if ((|I_QUEUE_WRITE_ENABLE) && w_q.config_bus_request_s[1] && w_q.alarm_n && used < {3'h0, cap})
    begin
      at_start = (w_q.q[sel].widx == 6'h00) && !w_q.half;
      if (I_INPUT_CELL_START != at_start)
        w_d.alarm_n = 1'b0;
      else
      begin
        commit = !in9 || w_q.half || (stuff && w_q.q[sel].widx == last);
        if (!commit)
        begin
          w_d.held = I_WRITE_DATA[8:0];
          w_d.half = 1'b1;
        end
        else
        begin
          // The stuffing byte of an odd-length cell is stored as zero.
          if (!in9)
            mem_wdata = I_WRITE_DATA;
          else if (w_q.half)
            mem_wdata = big ? {w_q.held, I_WRITE_DATA[8:0]} : {I_WRITE_DATA[8:0], w_q.held};
          else
            mem_wdata = big ? {I_WRITE_DATA[8:0], 9'h000} : {9'h000, I_WRITE_DATA[8:0]};
          mem_we    = 1'b1;
          mem_waddr = q_base(w_q.cfg[`TQF_IDX_Q1_LEN][4:0], w_q.cfg[`TQF_IDX_Q2_LEN][3:0], sel)
                      + w_q.q[sel].wptr;
          w_d.half  = 1'b0;
          w_d.q[sel].wptr = q_next(w_q.q[sel].wptr, cap);
          if (w_q.q[sel].widx == last)
          begin
            w_d.q[sel].widx   = 6'h00;
            w_d.q[sel].cstart = q_next(w_q.q[sel].wptr, cap);
            inc[sel]          = 1'b1;
            w_d.tog[sel]      = ~w_q.tog[sel];
          end
          else
            w_d.q[sel].widx = w_q.q[sel].widx + 6'h01;
        end
      end
    end

    for (int i = 0; i < 3; i++)
    begin
      w_d.q[i].cells = w_q.q[i].cells + {8'h00, inc[i]} - {8'h00, w_q.rtog_s2[i] ^ w_q.rtog_s3[i]};
      up = w_q.cfg[`TQF_IDX_Q1_UPPER + 4'(2 * i)];
      lo = w_q.cfg[`TQF_IDX_Q1_LOWER + 4'(2 * i)];
      if (w_d.q[i].cells >= up)
        w_d.q[i].flag = 1'b0;
      else if (w_d.q[i].cells <= lo)
        w_d.q[i].flag = 1'b1;
    end
  end

  // Reset is asynchronous; the outside holds it for six core clock cycles.
  always_ff @(posedge I_CORE_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      w_q         <= '0;
      w_q.cfg     <= CFG_RST;
      w_q.alarm_n <= 1'b1;
      w_q.ds_s    <= 3'h7;
      for (int i = 0; i < 3; i++)
        w_q.q[i].flag <= 1'b1;
    end
    else
      w_q <= w_d;
  end

  assign O_WRITE_READY           = w_q.config_bus_request_s[1];
  assign O_CELL_BOUNDARY_ALARM_N = w_q.alarm_n;
  assign O_PROG_RDATA            = w_q.rdata;
  assign O_THRESHOLD_FLAG        = {w_q.q[2].flag, w_q.q[1].flag, w_q.q[0].flag};

  ////////////////////////////////////////////////////////////////////////////
  // Read domain: queue select, byte split and complete-cell tracking.

  always_comb
  begin
    logic [1:0]  sel;
    logic [12:0] cap;
    logic [17:0] word;
    logic [5:0]  last;
    logic        adv;
    logic [2:0]  dec;
    sel  = 2'h0;
    cap  = 13'h0000;
    word = 18'h00000;
    last = 6'h00;
    adv  = 1'b0;
    dec  = 3'h0;
    r_d  = r_q;

    // Configuration only changes while the queues are idle, so a two-stage copy is settled before use.
    r_d.wtog_s1       = w_q.tog;
    r_d.wtog_s2       = r_q.wtog_s1;
    r_d.wtog_s3       = r_q.wtog_s2;
    r_d.cfg_s1        = {w_q.cfg[`TQF_IDX_Q1_LEN][4:0], w_q.cfg[`TQF_IDX_Q2_LEN][3:0],
                         w_q.cfg[`TQF_IDX_CELL_LEN][5:0], w_q.cfg[`TQF_IDX_FORMAT][`TQF_FMT_OUT_WIDTH],
                         w_q.cfg[`TQF_IDX_FORMAT][`TQF_FMT_OUT_DESTUFF]};
    r_d.cfg_s2        = r_q.cfg_s1;
    r_d.valid         = 1'b0;
    r_d.soc           = 1'b0;

    sel  = (I_QUEUE_SELECT == 2'h3) ? 2'h2 : ((I_QUEUE_SELECT == 2'h2) ? 2'h1 : 2'h0);
    cap  = q_cap(r_q.cfg_s2.q1_len, r_q.cfg_s2.q2_len, sel);
    last = r_q.cfg_s2.cell_len - 6'h01;

    if (I_READ_ENABLE && r_q.q[sel].rcells != 9'h000)
    begin
      word      = mem[q_base(r_q.cfg_s2.q1_len, r_q.cfg_s2.q2_len, sel) + r_q.q[sel].rptr];
      r_d.valid = 1'b1;
      r_d.soc   = (r_q.q[sel].ridx == 6'h00) && !r_q.half;
      if (!r_q.cfg_s2.out9)
      begin
        r_d.dout = word;
        adv      = 1'b1;
      end
      else
      begin
        // The half flag is shared, so a 9-bit reader finishes a word before switching queues.
        r_d.dout = r_q.half ? {word[17:9], word[17:9]} : {word[8:0], word[8:0]};
        adv      = r_q.half || (r_q.cfg_s2.destuff && r_q.q[sel].ridx == last);
        r_d.half = !adv;
      end
      if (adv)
      begin
        r_d.q[sel].rptr = q_next(r_q.q[sel].rptr, cap);
        if (r_q.q[sel].ridx == last)
        begin
          r_d.q[sel].ridx = 6'h00;
          dec[sel]        = 1'b1;
          r_d.tog[sel]    = ~r_q.tog[sel];
        end
        else
          r_d.q[sel].ridx = r_q.q[sel].ridx + 6'h01;
      end
    end

    for (int i = 0; i < 3; i++)
    begin
      r_d.q[i].rcells = r_q.q[i].rcells + {8'h00, r_q.wtog_s2[i] ^ r_q.wtog_s3[i]} - {8'h00, dec[i]};
      r_d.cready[i]   = r_d.q[i].rcells != 9'h000;
    end
  end

  always_ff @(posedge I_READ_CLK or posedge I_RST)
  begin
    if (I_RST)
      r_q <= '0;
    else
      r_q <= r_d;
  end

  assign O_READ_DATA  = r_q.dout;
  assign O_READ_VALID = r_q.valid;
  assign O_CELL_START = r_q.soc;
  assign O_CELL_READY = r_q.cready;

endmodule

// ===== logic/tqf_pkg.sv
// Types shared by the three-queue cell FIFO.
package tqf_pkg;

  typedef logic [9:0][8:0] tqf_cfg_t;

  typedef struct packed {
    logic [11:0] wptr;
    logic [11:0] cstart;
    logic [5:0]  widx;
    logic [8:0]  cells;
    logic        flag;
  } tqf_wq_t;

  typedef struct packed {
    tqf_wq_t [2:0] q;
    tqf_cfg_t      cfg;
    logic [3:0]    cfg_cnt;
    logic          half;
    logic [8:0]    held;
    logic          alarm_n;
    logic [2:0]    tog;
    logic [1:0]    config_bus_request_s;
    logic [2:0]    ds_s;
    logic [7:0]    p_s1;
    logic [7:0]    p_s2;
    logic [3:0]    a_s1;
    logic [3:0]    a_s2;
    logic [2:0]    rtog_s1;
    logic [2:0]    rtog_s2;
    logic [2:0]    rtog_s3;
    logic [8:0]    rdata;
  } tqf_wr_t;

  typedef struct packed {
    logic [4:0] q1_len;
    logic [3:0] q2_len;
    logic [5:0] cell_len;
    logic       out9;
    logic       destuff;
  } tqf_rcfg_t;

  typedef struct packed {
    logic [11:0] rptr;
    logic [5:0]  ridx;
    logic [8:0]  rcells;
  } tqf_rq_t;

  typedef struct packed {
    tqf_rq_t [2:0] q;
    logic          half;
    logic [2:0]    tog;
    logic [2:0]    wtog_s1;
    logic [2:0]    wtog_s2;
    logic [2:0]    wtog_s3;
    tqf_rcfg_t     cfg_s1;
    tqf_rcfg_t     cfg_s2;
    logic [17:0]   dout;
    logic          valid;
    logic          soc;
    logic [2:0]    cready;
  } tqf_rd_t;

endpackage

// ===== logic/tqf_regs.svh
// Register indices, reset values, field positions and sizes of the three-queue cell FIFO.
`ifndef TQF_REGS_SVH
`define TQF_REGS_SVH

`define TQF_IDX_FORMAT      4'h0
`define TQF_IDX_Q1_LEN      4'h1
`define TQF_IDX_Q2_LEN      4'h2
`define TQF_IDX_CELL_LEN    4'h3
`define TQF_IDX_Q1_UPPER    4'h4
`define TQF_IDX_Q1_LOWER    4'h5
`define TQF_IDX_Q2_UPPER    4'h6
`define TQF_IDX_Q2_LOWER    4'h7
`define TQF_IDX_Q3_UPPER    4'h8
`define TQF_IDX_Q3_LOWER    4'h9
`define TQF_IDX_Q3_LEN      4'hA
`define TQF_NUM_WRITABLE    4'hA

`define TQF_RST_FORMAT      9'h000
`define TQF_RST_Q1_LEN      9'h008
`define TQF_RST_Q2_LEN      9'h006
`define TQF_RST_CELL_LEN    9'h01B
`define TQF_RST_Q1_UPPER    9'h047
`define TQF_RST_Q1_LOWER    9'h046
`define TQF_RST_Q2_UPPER    9'h033
`define TQF_RST_Q2_LOWER    9'h032
`define TQF_RST_Q3_UPPER    9'h00D
`define TQF_RST_Q3_LOWER    9'h00C

`define TQF_MSK_FORMAT      9'h01F
`define TQF_MSK_Q1_LEN      9'h01F
`define TQF_MSK_Q2_LEN      9'h00F
`define TQF_MSK_CELL_LEN    9'h03F
`define TQF_MSK_THR9        9'h1FF
`define TQF_MSK_THR8        9'h0FF

`define TQF_FMT_IN_WIDTH    0
`define TQF_FMT_IN_ORDER    1
`define TQF_FMT_IN_STUFF    2
`define TQF_FMT_OUT_WIDTH   3
`define TQF_FMT_OUT_DESTUFF 4

`define TQF_TOTAL_BLOCKS    5'h10
`define TQF_BLOCK_SHIFT     8
`define TQF_MEM_WORDS       4096

`endif
